// ### hdl/dual_loop_synth_mode_config.sv
`timescale 1ns/1ps
module dual_loop_synth_mode_config (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // serial control port, sampled on ref_clk_i
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_oe_n_o,
   // strap
   input wire logic master_strap_i,
   // loop configuration
   output synth_cfg_pkg::loop_cfg_s loop_cfg_o,
   output synth_cfg_pkg::mode_decode_s mode_o,
   output logic [3:0] mode_sel_o,
   output logic cfg_update_o
);

   // ------------------------------------------------------------
   // registers and port state
   // ------------------------------------------------------------
   logic [4:0] mode_and_loop_a_ctrl_r;
   logic [4:0] ref_multiple_and_loop_b_ctrl_r;
   logic [4:0] out_a_factor_sel_r;
   logic sclk_d_r;
   logic [4:0] bit_cnt_r;
   logic read_r;
   logic [3:0] addr_r;
   logic [7:0] wdata_r;
   logic [4:0] rd_shift_r;
   logic rd_active_r;
   logic wr_done_r;
   logic [4:0] rd_word;
   logic rise;
   logic fall;
   logic [3:0] n_field;
   synth_cfg_pkg::mode_decode_s dec;

   // ------------------------------------------------------------
   // serial clock edge detect, idle low so no edge after reset
   // ------------------------------------------------------------
   assign rise = serial_clk_i & ~sclk_d_r;
   assign fall = ~serial_clk_i & sclk_d_r;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= serial_clk_i;
      end
   end

   // ------------------------------------------------------------
   // serial frame: direction, address, data
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_cnt_r <= 5'h00;
         read_r <= 1'b0;
         addr_r <= 4'h0;
         wdata_r <= 8'h00;
      end else if (chip_select_n_i) begin
         bit_cnt_r <= 5'h00;
      end else if (rise) begin
         if (bit_cnt_r != 5'h1f) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
         if (bit_cnt_r == 5'h00) begin
            read_r <= serial_in_i;
         end
         if (bit_cnt_r >= 5'(synth_cfg_pkg::ADDR_FIRST) &&
             bit_cnt_r < 5'(synth_cfg_pkg::ADDR_FIRST + synth_cfg_pkg::ADDR_W)) begin
            addr_r <= {serial_in_i, addr_r[3:1]};
         end
         if (bit_cnt_r >= 5'(synth_cfg_pkg::HDR_BITS) &&
             bit_cnt_r < 5'(synth_cfg_pkg::HDR_BITS + synth_cfg_pkg::WR_BITS)) begin
            wdata_r <= {serial_in_i, wdata_r[7:1]};
         end
      end
   end

   // write completes on the last data rising edge
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_done_r <= 1'b0;
      end else begin
         wr_done_r <= !chip_select_n_i && rise && !read_r &&
                      bit_cnt_r == 5'(synth_cfg_pkg::HDR_BITS + synth_cfg_pkg::WR_BITS - 1);
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_and_loop_a_ctrl_r <= synth_cfg_pkg::MODE_AND_LOOP_A_CTRL_RST;
         ref_multiple_and_loop_b_ctrl_r <= synth_cfg_pkg::REF_MULTIPLE_AND_LOOP_B_CTRL_RST;
         out_a_factor_sel_r <= synth_cfg_pkg::OUT_A_FACTOR_SEL_RST;
      end else if (wr_done_r) begin
         case (addr_r)
            synth_cfg_pkg::MODE_AND_LOOP_A_CTRL_ADDR: begin
               mode_and_loop_a_ctrl_r <= wdata_r[4:0];
            end
            synth_cfg_pkg::REF_MULTIPLE_AND_LOOP_B_CTRL_ADDR: begin
               ref_multiple_and_loop_b_ctrl_r <= wdata_r[4:0];
            end
            synth_cfg_pkg::OUT_A_FACTOR_SEL_ADDR: begin
               out_a_factor_sel_r <= wdata_r[4:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (addr_r)
         synth_cfg_pkg::MODE_AND_LOOP_A_CTRL_ADDR: rd_word = mode_and_loop_a_ctrl_r;
         synth_cfg_pkg::REF_MULTIPLE_AND_LOOP_B_CTRL_ADDR: rd_word = ref_multiple_and_loop_b_ctrl_r;
         synth_cfg_pkg::OUT_A_FACTOR_SEL_ADDR: rd_word = out_a_factor_sel_r;
         default: rd_word = 5'h00;
      endcase
   end

   // ------------------------------------------------------------
   // read data, shifted out on falling serial clock edges
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_shift_r <= 5'h00;
         rd_active_r <= 1'b0;
         serial_out_o <= 1'b0;
      end else if (chip_select_n_i) begin
         rd_active_r <= 1'b0;
         serial_out_o <= 1'b0;
      end else if (fall && read_r) begin
         if (bit_cnt_r == 5'(synth_cfg_pkg::RD_FIRST_FALL)) begin
            rd_active_r <= 1'b1;
            serial_out_o <= rd_word[0];
            rd_shift_r <= {1'b0, rd_word[4:1]};
         end else if (bit_cnt_r ==
                      5'(synth_cfg_pkg::RD_FIRST_FALL + synth_cfg_pkg::DATA_W)) begin
            rd_active_r <= 1'b0;
         end else if (rd_active_r) begin
            serial_out_o <= rd_shift_r[0];
            rd_shift_r <= {1'b0, rd_shift_r[4:1]};
         end
      end
   end

   assign serial_out_oe_n_o = ~rd_active_r;

   // ------------------------------------------------------------
   // mode decode and loop configuration
   // ------------------------------------------------------------
   synth_mode_decode u_decode (
      .mode_i(mode_and_loop_a_ctrl_r[synth_cfg_pkg::FIELD_MSB:synth_cfg_pkg::FIELD_LSB]),
      .master_i(master_strap_i),
      .dec_o(dec)
   );

   assign mode_o = dec;
   assign mode_sel_o = mode_and_loop_a_ctrl_r[synth_cfg_pkg::FIELD_MSB:synth_cfg_pkg::FIELD_LSB];
   assign cfg_update_o = wr_done_r;
   assign n_field = ref_multiple_and_loop_b_ctrl_r[synth_cfg_pkg::FIELD_MSB:synth_cfg_pkg::FIELD_LSB];

   // ------------------------------------------------------------
   // loop configuration: multiples only where the mode uses them
   // ------------------------------------------------------------
   always_comb begin
      loop_cfg_o = '0;
      loop_cfg_o.loop_a_enable = mode_and_loop_a_ctrl_r[synth_cfg_pkg::ENABLE_BIT];
      loop_cfg_o.loop_b_enable = ref_multiple_and_loop_b_ctrl_r[synth_cfg_pkg::ENABLE_BIT];
      case (dec.op)
         synth_cfg_pkg::OP_FORWARD: begin
            loop_cfg_o.ref_multiple_n = n_field;
            loop_cfg_o.out_a_factor = out_a_factor_sel_r;
         end
         synth_cfg_pkg::OP_E1_TO_T1: begin
            loop_cfg_o.ref_multiple_n = n_field;
         end
         synth_cfg_pkg::OP_FRACTIONAL: begin
            loop_cfg_o.input_multiple_p = out_a_factor_sel_r;
         end
         default: begin
            // fixed-ratio modes take no multiple from the registers
            loop_cfg_o.ref_multiple_n = 4'h0;
         end
      endcase
   end

endmodule : dual_loop_synth_mode_config

// ### pkg/synth_cfg_pkg.sv
package synth_cfg_pkg;

   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 5;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] MODE_AND_LOOP_A_CTRL_ADDR = 4'h0;
   localparam logic [3:0] REF_MULTIPLE_AND_LOOP_B_CTRL_ADDR = 4'h1;
   localparam logic [3:0] OUT_A_FACTOR_SEL_ADDR = 4'h2;
   localparam logic [4:0] MODE_AND_LOOP_A_CTRL_RST = 5'h00;
   localparam logic [4:0] REF_MULTIPLE_AND_LOOP_B_CTRL_RST = 5'h00;
   localparam logic [4:0] OUT_A_FACTOR_SEL_RST = 5'h00;
   localparam int unsigned ENABLE_BIT = 0;
   localparam int unsigned FIELD_LSB = 1;
   localparam int unsigned FIELD_MSB = 4;

   // ------------------------------------------------------------
   // serial frame layout, in rising serial clock edges
   // ------------------------------------------------------------
   localparam int unsigned HDR_BITS = 8;
   localparam int unsigned ADDR_FIRST = 1;
   localparam int unsigned WR_BITS = 8;
   localparam int unsigned RD_FIRST_FALL = 8;

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_FORWARD = 3'b000,
      OP_REVERSE = 3'b001,
      OP_E1_TO_T1 = 3'b010,
      OP_FRACTIONAL = 3'b011,
      OP_HIGH_SPEED = 3'b100,
      OP_RESERVED = 3'b101
   } op_mode_e;

   typedef enum logic [2:0] {
      REF_N_T1 = 3'b000,
      REF_N_E1 = 3'b001,
      REF_56K = 3'b010,
      REF_64K = 3'b011,
      REF_P_56K = 3'b100,
      REF_P_64K = 3'b101,
      REF_8K = 3'b110,
      REF_NONE = 3'b111
   } ref_kind_e;

   typedef enum logic [2:0] {
      OUT_K_56K = 3'b000,
      OUT_K_64K = 3'b001,
      OUT_T1 = 3'b010,
      OUT_E1 = 3'b011,
      OUT_M_E1 = 3'b100,
      OUT_HOLD = 3'b101
   } out_kind_e;

   typedef struct packed {
      op_mode_e op;
      ref_kind_e ref_kind;
      out_kind_e out_a;
      out_kind_e out_b;
   } mode_decode_s;

   typedef struct packed {
      logic loop_a_enable;
      logic loop_b_enable;
      logic [3:0] ref_multiple_n;
      logic [4:0] out_a_factor;
      logic [4:0] input_multiple_p;
   } loop_cfg_s;

endpackage : synth_cfg_pkg

// ### hdl/synth_mode_decode.sv
`timescale 1ns/1ps
module synth_mode_decode (
   // selection
   input wire logic [3:0] mode_i,
   input wire logic master_i,
   // decoded mode
   output synth_cfg_pkg::mode_decode_s dec_o
);

   always_comb begin
      dec_o = '{synth_cfg_pkg::OP_RESERVED, synth_cfg_pkg::REF_NONE,
                synth_cfg_pkg::OUT_HOLD, synth_cfg_pkg::OUT_HOLD};
      case (mode_i)
         4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6: begin
            dec_o.op = synth_cfg_pkg::OP_FORWARD;
            dec_o.ref_kind = mode_i[2] ? synth_cfg_pkg::REF_N_E1 : synth_cfg_pkg::REF_N_T1;
            dec_o.out_a = (mode_i[1:0] == 2'h2) ? synth_cfg_pkg::OUT_K_64K
                                                 : synth_cfg_pkg::OUT_K_56K;
            dec_o.out_b = (mode_i[1:0] == 2'h0) ? synth_cfg_pkg::OUT_K_56K
                                                 : synth_cfg_pkg::OUT_K_64K;
         end
         4'h3, 4'h7: begin
            dec_o.op = synth_cfg_pkg::OP_REVERSE;
            dec_o.ref_kind = mode_i[2] ? synth_cfg_pkg::REF_64K : synth_cfg_pkg::REF_56K;
            dec_o.out_a = synth_cfg_pkg::OUT_T1;
            dec_o.out_b = synth_cfg_pkg::OUT_E1;
         end
         4'h8: begin
            if (master_i) begin
               dec_o.op = synth_cfg_pkg::OP_E1_TO_T1;
               dec_o.ref_kind = synth_cfg_pkg::REF_N_E1;
               dec_o.out_a = synth_cfg_pkg::OUT_T1;
               dec_o.out_b = synth_cfg_pkg::OUT_T1;
            end else begin
               dec_o.op = synth_cfg_pkg::OP_REVERSE;
               dec_o.out_a = synth_cfg_pkg::OUT_K_56K;
               dec_o.out_b = synth_cfg_pkg::OUT_K_64K;
            end
         end
         4'h9, 4'ha, 4'hb, 4'hc: begin
            dec_o.op = synth_cfg_pkg::OP_FRACTIONAL;
            dec_o.ref_kind = (mode_i <= 4'ha) ? synth_cfg_pkg::REF_P_56K
                                              : synth_cfg_pkg::REF_P_64K;
            dec_o.out_a = (mode_i <= 4'ha) ? synth_cfg_pkg::OUT_T1 : synth_cfg_pkg::OUT_E1;
            dec_o.out_b = (mode_i == 4'h9 || mode_i == 4'hc) ? synth_cfg_pkg::OUT_E1
                                                             : synth_cfg_pkg::OUT_T1;
         end
         4'hd: begin
            dec_o.op = synth_cfg_pkg::OP_HIGH_SPEED;
            dec_o.ref_kind = synth_cfg_pkg::REF_64K;
            dec_o.out_a = synth_cfg_pkg::OUT_M_E1;
            dec_o.out_b = synth_cfg_pkg::OUT_M_E1;
         end
         default: begin
            dec_o.op = synth_cfg_pkg::OP_RESERVED;
         end
      endcase
      // slave table: every mode below high speed (codes 0 to 12) takes the 8 kHz reference
      if (!master_i && mode_i <= 4'hc) begin
         dec_o.ref_kind = synth_cfg_pkg::REF_8K;
         if (mode_i >= 4'h9) begin
            dec_o.op = synth_cfg_pkg::OP_REVERSE;
         end
      end
   end

endmodule : synth_mode_decode

// ### sim/dual_loop_synth_mode_config_checker.sv
`timescale 1ns/1ps
module dual_loop_synth_mode_config_checker (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // serial port
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n_o,
   // strap and configuration
   input wire logic master_strap_i,
   input wire synth_cfg_pkg::loop_cfg_s loop_cfg_o,
   input wire synth_cfg_pkg::mode_decode_s mode_o,
   input wire logic [3:0] mode_sel_o,
   input wire logic cfg_update_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_update_one_cycle: assert property (cfg_update_o |=> !cfg_update_o)
      else $error("update pulse longer than one cycle");
   a_mode_on_write: assert property ($changed(mode_sel_o) |-> $past(cfg_update_o))
      else $error("mode field changed without a write");
   a_loop_a_on_write: assert property ($changed(loop_cfg_o.loop_a_enable) |->
      $past(cfg_update_o))
      else $error("loop a enable changed without a write");
   a_loop_b_on_write: assert property ($changed(loop_cfg_o.loop_b_enable) |->
      $past(cfg_update_o))
      else $error("loop b enable changed without a write");
   a_oe_off_idle: assert property (chip_select_n_i [*3] |-> serial_out_oe_n_o)
      else $error("read driver on while deselected");
   a_oe_on_fall: assert property ($fell(serial_out_oe_n_o) |-> !chip_select_n_i && !serial_clk_i)
      else $error("read driver turned on outside a falling phase");
   a_reserved_hold: assert property (mode_sel_o[3:1] == 3'b111 |->
      mode_o.op == synth_cfg_pkg::OP_RESERVED && mode_o.out_a == synth_cfg_pkg::OUT_HOLD)
      else $error("reserved code not decoded as reserved");
   a_high_speed: assert property (mode_sel_o == 4'hd |->
      mode_o.op == synth_cfg_pkg::OP_HIGH_SPEED && mode_o.ref_kind == synth_cfg_pkg::REF_64K)
      else $error("high speed code misdecoded");
   a_slave_ref: assert property (!master_strap_i && mode_sel_o < 4'hd |->
      mode_o.ref_kind == synth_cfg_pkg::REF_8K)
      else $error("slave table reference not 8k");
   a_p_only_frac: assert property (mode_o.op != synth_cfg_pkg::OP_FRACTIONAL |->
      loop_cfg_o.input_multiple_p == 5'h00)
      else $error("input multiple set outside fractional mode");
   a_k_only_fwd: assert property (mode_o.op != synth_cfg_pkg::OP_FORWARD |->
      loop_cfg_o.out_a_factor == 5'h00)
      else $error("output multiple set outside forward mode");
   a_n_only_fwd: assert property (mode_o.op != synth_cfg_pkg::OP_FORWARD &&
      mode_o.op != synth_cfg_pkg::OP_E1_TO_T1 |-> loop_cfg_o.ref_multiple_n == 4'h0)
      else $error("reference multiple set outside forward modes");
endmodule : dual_loop_synth_mode_config_checker

bind dual_loop_synth_mode_config dual_loop_synth_mode_config_checker u_checker (.ref_clk_i,
   .rst_b_i, .chip_select_n_i, .serial_clk_i, .serial_in_i, .serial_out_o, .serial_out_oe_n_o,
   .master_strap_i, .loop_cfg_o, .mode_o, .mode_sel_o, .cfg_update_o);

// ### sim/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   // clock
   input wire logic ref_clk_i,
   // serial port
   output logic chip_select_n_o,
   output logic serial_clk_o,
   output logic serial_in_o,
   input wire logic serial_out_i,
   input wire logic serial_out_oe_n_i
);
   initial begin
      chip_select_n_o = 1'b1;
      serial_clk_o = 1'b0;
      serial_in_o = 1'b0;
   end
   // one frame, cut short by deselect when nbits is below the full count
   task automatic frame(input logic rd, input logic [3:0] addr, input logic [7:0] wdata,
                        input int nbits, output logic [4:0] rdata, output logic oe_ok);
      logic [15:0] bits;
      bits = {wdata, 3'b000, addr, rd};
      rdata = 5'h00;
      oe_ok = 1'b1;
      @(posedge ref_clk_i);
      chip_select_n_o <= 1'b0;
      for (int k = 0; k < nbits; k++) begin
         serial_clk_o <= 1'b0;
         serial_in_o <= bits[k];
         repeat (3) @(posedge ref_clk_i);
         if (rd && k >= 8) begin
            // a released line shows the inverse so a missing driver is caught
            rdata[k - 8] = serial_out_oe_n_i ? ~serial_out_i : serial_out_i;
            oe_ok &= !serial_out_oe_n_i;
         end
         serial_clk_o <= 1'b1;
         repeat (3) @(posedge ref_clk_i);
      end
      serial_clk_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chip_select_n_o <= 1'b1;
      serial_in_o <= ~serial_in_o;
      repeat (3) @(posedge ref_clk_i);
   endtask : frame
endmodule : serial_host_model

// ### sim/tb_dual_loop_synth_mode_config.sv
`timescale 1ns/1ps
module tb_dual_loop_synth_mode_config;
   logic ref_clk_i, rst_b_i, chip_select_n_i, serial_clk_i, serial_in_i, serial_out_o;
   logic serial_out_oe_n_o, master_strap_i, cfg_update_o;
   logic [3:0] mode_sel_o;
   synth_cfg_pkg::loop_cfg_s loop_cfg_o;
   synth_cfg_pkg::mode_decode_s mode_o;
   synth_cfg_pkg::op_mode_e op;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int regs[3] = '{0, 0, 0};
   logic [4:0] rdata;
   logic ok;

   dual_loop_synth_mode_config dut (.ref_clk_i, .rst_b_i, .chip_select_n_i, .serial_clk_i,
      .serial_in_i, .serial_out_o, .serial_out_oe_n_o, .master_strap_i, .loop_cfg_o, .mode_o,
      .mode_sel_o, .cfg_update_o);
   serial_host_model host (.ref_clk_i, .chip_select_n_o(chip_select_n_i),
      .serial_clk_o(serial_clk_i), .serial_in_o(serial_in_i), .serial_out_i(serial_out_o),
      .serial_out_oe_n_i(serial_out_oe_n_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic wr(input int a, input int d, input int nb = 16);
      host.frame(1'b0, a[3:0], d[7:0], nb, rdata, ok);
      if (a < 3 && nb == 16) regs[a] = d & 31;
   endtask : wr
   task automatic rd_chk(input int a);
      host.frame(1'b1, a[3:0], 8'h00, 13, rdata, ok);
      check(rdata, (a < 3) ? regs[a] : 0, "read data");
      check(ok, 1, "read driver");
   endtask : rd_chk
   function automatic synth_cfg_pkg::op_mode_e exp_op(int c, logic m);
      if (c >= 14) return synth_cfg_pkg::OP_RESERVED;
      if (c == 13) return synth_cfg_pkg::OP_HIGH_SPEED;
      if (c == 3 || c == 7 || (!m && c >= 8)) return synth_cfg_pkg::OP_REVERSE;
      if (c < 8) return synth_cfg_pkg::OP_FORWARD;
      return (c == 8) ? synth_cfg_pkg::OP_E1_TO_T1 : synth_cfg_pkg::OP_FRACTIONAL;
   endfunction : exp_op
   function automatic logic [2:0] exp_ref(int c, logic m);
      if (c >= 14) return synth_cfg_pkg::REF_NONE;
      if (c == 13) return synth_cfg_pkg::REF_64K;
      if (!m) return synth_cfg_pkg::REF_8K;
      if (c < 3) return synth_cfg_pkg::REF_N_T1;
      if (c == 3) return synth_cfg_pkg::REF_56K;
      if (c == 7) return synth_cfg_pkg::REF_64K;
      if (c < 9) return synth_cfg_pkg::REF_N_E1;
      return (c < 11) ? synth_cfg_pkg::REF_P_56K : synth_cfg_pkg::REF_P_64K;
   endfunction : exp_ref
   function automatic logic [5:0] exp_out(int c, logic m);
      case (c)
         0, 4: return {synth_cfg_pkg::OUT_K_56K, synth_cfg_pkg::OUT_K_56K};
         1, 5: return {synth_cfg_pkg::OUT_K_56K, synth_cfg_pkg::OUT_K_64K};
         2, 6: return {synth_cfg_pkg::OUT_K_64K, synth_cfg_pkg::OUT_K_64K};
         3, 7, 9: return {synth_cfg_pkg::OUT_T1, synth_cfg_pkg::OUT_E1};
         8: return m ? {synth_cfg_pkg::OUT_T1, synth_cfg_pkg::OUT_T1}
                     : {synth_cfg_pkg::OUT_K_56K, synth_cfg_pkg::OUT_K_64K};
         10: return {synth_cfg_pkg::OUT_T1, synth_cfg_pkg::OUT_T1};
         11: return {synth_cfg_pkg::OUT_E1, synth_cfg_pkg::OUT_T1};
         12: return {synth_cfg_pkg::OUT_E1, synth_cfg_pkg::OUT_E1};
         13: return {synth_cfg_pkg::OUT_M_E1, synth_cfg_pkg::OUT_M_E1};
         default: return {synth_cfg_pkg::OUT_HOLD, synth_cfg_pkg::OUT_HOLD};
      endcase
   endfunction : exp_out

   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_b_i = 1'b0;
      master_strap_i = 1'b1;
      void'($urandom(32'h352da0e5));
      repeat (6) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      for (int a = 0; a < 3; a++) rd_chk(a);
      $display("test reset_values done");
      for (int s = 1; s >= 0; s--) begin
         master_strap_i <= s[0];
         wr(1, $urandom);
         wr(2, $urandom);
         for (int c = 0; c < 16; c++) begin
            wr(0, c * 2 + $urandom % 2 + ($urandom % 8) * 32);
            op = exp_op(c, s[0]);
            check(mode_o.op, op, "mode");
            check(mode_o.ref_kind, exp_ref(c, s[0]), "ref kind");
            check(mode_sel_o, c, "mode field");
            check({mode_o.out_a, mode_o.out_b}, exp_out(c, s[0]), "out kinds");
            check(loop_cfg_o.loop_a_enable, regs[0] & 1, "loop a");
            check(loop_cfg_o.loop_b_enable, regs[1] & 1, "loop b");
            check(loop_cfg_o.ref_multiple_n, (op == synth_cfg_pkg::OP_FORWARD ||
               op == synth_cfg_pkg::OP_E1_TO_T1) ? regs[1] >> 1 : 0, "n");
            check(loop_cfg_o.out_a_factor, (op == synth_cfg_pkg::OP_FORWARD) ? regs[2] : 0,
               "k");
            check(loop_cfg_o.input_multiple_p,
               (op == synth_cfg_pkg::OP_FRACTIONAL) ? regs[2] : 0, "p");
            if (!s[0] && c == 8) check({mode_o.out_a, mode_o.out_b},
               {synth_cfg_pkg::OUT_K_56K, synth_cfg_pkg::OUT_K_64K}, "slave k");
            if (c % 4 == 1) rd_chk(0);
         end
         rd_chk(1);
         rd_chk(2);
      end
      $display("test mode_sweep done");
      wr(5, 8'h1f);
      wr(0, 8'h1b, 12);
      rd_chk(5);
      rd_chk(0);
      $display("test refusals done");
      close_out();
   end
endmodule : tb_dual_loop_synth_mode_config
